// file: hdl/fec_rx_pkg.sv
// Shared constants for the repair-packet header parser
package fec_rx_pkg;
	// Clock and time base
	localparam int CLK_PERIOD_NS = 10;
	localparam int NS_PER_US = 1000;
	localparam int CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;
	localparam logic [31:0] MIN_RATE_HZ = 32'h0000_03e8;

	// Register byte offsets
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_STATUS = 12'h004;
	localparam logic [11:0] REG_RATE = 12'h008;
	localparam logic [11:0] REG_WINDOW = 12'h00c;
	localparam logic [11:0] REG_LAYOUT = 12'h010;
	localparam logic [11:0] REG_SRC_SSRC = 12'h014;
	localparam logic [11:0] REG_HDR0 = 12'h018;
	localparam logic [11:0] REG_TSREC = 12'h01c;
	localparam logic [11:0] REG_RTP_SN = 12'h020;
	localparam logic [11:0] REG_RTP_TS = 12'h024;
	localparam logic [11:0] REG_REP_SSRC = 12'h028;
	localparam logic [11:0] REG_PKT_COUNT = 12'h02c;

	// Reset values
	localparam logic [31:0] RATE_RST = 32'h0001_5f90;
	localparam logic [31:0] WINDOW_RST = 32'h0000_0000;
	localparam logic [7:0] L_RST = 8'h01;
	localparam logic [7:0] D_RST = 8'h01;

	// Layout register fields
	localparam int LAY_L_LSB = 0;
	localparam int LAY_D_LSB = 8;
	localparam int LAY_TOP_LSB = 16;

	// Status bits; 0..7 sticky write-one-to-clear, 8..9 live
	localparam int ST_MARKER = 0;
	localparam int ST_SEQ = 1;
	localparam int ST_SSRC = 2;
	localparam int ST_SESSION = 3;
	localparam int ST_PATTERN = 4;
	localparam int ST_FORMAT = 5;
	localparam int ST_WINDOW = 6;
	localparam int ST_CFG = 7;
	localparam int ST_HDR_VALID = 8;
	localparam int ST_BUSY = 9;
	localparam int STICKY_W = 8;

	// Header bit positions
	localparam int RTP_M_BIT = 23;
	localparam int RTP_CC_LSB = 24;
	localparam int FEC_R_BIT = 31;
	localparam int FEC_F_BIT = 30;
	localparam int FEC_CC_LSB = 24;
	localparam int BLK_K_BIT = 15;
	localparam int MASK1_K_BIT = 31;

	// Mask lengths of the chained blocks
	localparam logic [7:0] MASK_LEN0 = 8'h0f;
	localparam logic [7:0] MASK_LEN1 = 8'h2e;
	localparam logic [7:0] MASK_LEN2 = 8'h6e;

	// Protection type codes
	localparam logic [1:0] TOP_INTERLEAVED = 2'h0;
	localparam logic [1:0] TOP_NONINTERLEAVED = 2'h1;
	localparam logic [1:0] TOP_TWO_D = 2'h2;
	localparam logic [1:0] TOP_RESERVED = 2'h3;

	typedef enum logic [1:0] {EXP_FLEX, EXP_FIXED, EXP_SINGLE} exp_mode_t;

	// Sequence arithmetic wraps at 16 bits
	function automatic logic [15:0] sn_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[15:0];
	endfunction
endpackage

// file: hdl/fec_sn_expander.sv
// Expands one protection description into protected sequence numbers
`timescale 1ns/1ns
module fec_sn_expander (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Description
	input wire logic start,
	input wire fec_rx_pkg::exp_mode_t mode,
	input wire logic [15:0] base,
	input wire logic [0:109] mask,
	input wire logic [7:0] mask_len,
	input wire logic [7:0] m_off,
	input wire logic [7:0] n_cnt,
	output logic busy,
	// Protected sequence numbers
	output logic out_valid,
	input wire logic out_ready,
	output logic [15:0] out_sn
);
	logic [7:0] idx;
	logic [7:0] limit;
	logic hit;
	logic [15:0] cand;
	logic [15:0] col_off;

	// Widen before the product so large M times N does not wrap at 8 bits
	assign col_off = {8'h00, m_off} * {8'h00, idx};

	always_comb begin
		limit = 8'h00;
		hit = 1'b1;
		cand = base;
		unique case (mode)
			fec_rx_pkg::EXP_FLEX: begin
				limit = mask_len - 8'h01;
				hit = mask[idx];
				cand = fec_rx_pkg::sn_add(base, {8'h00, idx} + 16'h0001);
			end
			fec_rx_pkg::EXP_FIXED: begin
				if (n_cnt > 8'h01) begin
					limit = n_cnt;
					cand = fec_rx_pkg::sn_add(base, col_off);
				end else begin
					limit = m_off;
					cand = fec_rx_pkg::sn_add(base, {8'h00, idx});
				end
			end
			fec_rx_pkg::EXP_SINGLE: begin
				limit = 8'h00;
			end
			default: begin
				limit = 8'h00;
				hit = 1'b0;
			end
		endcase
	end

	// One candidate at a time; unset mask bits cost a cycle each, a hit at least two
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idx <= 8'h00;
			busy <= 1'b0;
			out_valid <= 1'b0;
			out_sn <= 16'h0000;
		end else if (start) begin
			idx <= 8'h00;
			busy <= 1'b1;
			out_valid <= 1'b0;
		end else if (busy) begin
			if (out_valid) begin
				if (out_ready) begin
					out_valid <= 1'b0;
					if (idx == limit) begin
						busy <= 1'b0;
					end
					idx <= idx + 8'h01;
				end
			end else if (idx > limit) begin
				busy <= 1'b0;
			end else if (hit) begin
				out_sn <= cand;
				out_valid <= 1'b1;
			end else if (idx == limit) begin
				busy <= 1'b0;
			end else begin
				idx <= idx + 8'h01;
			end
		end
	end
endmodule

// file: hdl/fec_repair_parser.sv
// Receiver-side parser and checker for incoming repair packet headers
`timescale 1ns/1ns
// Contract
// - R bit marks retransmission versus repair
// - F bit selects bitmask or M/N
// - Recovery fields P X CC M PT
// - Sixteen-bit length recovery field present
// - Thirty-two-bit timestamp recovery field present
// - One CSRC and block per protected SSRC
// - Block opens with lowest sequence base
// - Mask bit j protects base+j+1
// - k bit chains 15/46/110-bit masks
// - N zero or one means row
// - N above one means column
// - R and F set retransmit one packet
// - Retransmission layout drops sixty-four bits; the parser drops only the one 32-bit block word
// - Repair clock rate above 1000 Hz
// - Protection type codes; three reserved
// - Repair window counted in microseconds
// - L columns and D rows
module fec_repair_parser (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// Repair packet word stream
	input wire logic s_valid,
	input wire logic s_sop,
	input wire logic s_eop,
	input wire logic [31:0] s_data,
	output logic s_ready,
	// Protected sequence numbers for the recovery engine
	output logic prot_valid,
	input wire logic prot_ready,
	output logic [15:0] prot_sn,
	output logic [31:0] prot_ssrc
);
	typedef enum {ST_IDLE, ST_RTP1, ST_RTP2, ST_FEC0, ST_FEC1, ST_CSRC, ST_BLK0,
		ST_MASK1, ST_MASK2, ST_MASK3, ST_EXPAND, ST_SKIP} parse_state_t;

	parse_state_t state;
	parse_state_t next_state;
	logic take;
	logic ctrl_en;
	logic [31:0] rate;
	logic [31:0] window_us;
	logic [7:0] cfg_l;
	logic [7:0] cfg_d;
	logic [1:0] cfg_top;
	logic [31:0] src_ssrc;
	logic [fec_rx_pkg::STICKY_W-1:0] status;
	logic [fec_rx_pkg::STICKY_W-1:0] set_bits;
	logic hdr_valid;
	logic [31:0] hdr0;
	logic [31:0] ts_rec;
	logic [15:0] rtp_sn;
	logic [31:0] rtp_ts;
	logic [31:0] rep_ssrc;
	logic [31:0] pkt_count;
	logic have_sn;
	logic have_ssrc;
	logic [3:0] blocks_left;
	logic is_retx;
	logic f_fixed;
	logic [15:0] base;
	logic [0:109] mask;
	logic [7:0] mask_len;
	logic [7:0] fm;
	logic [7:0] fn;
	logic exp_start;
	logic exp_busy;
	logic eop_seen;
	fec_rx_pkg::exp_mode_t exp_mode;
	logic wr;
	logic addr_ok;
	logic [31:0] rd_val;
	logic [6:0] us_div;
	logic [31:0] win_cnt;
	logic us_tick;

	assign take = s_valid && s_ready;
	// Stall the link while a block is expanded so no header word is lost
	assign s_ready = (state != ST_EXPAND);
	assign exp_mode = is_retx ? fec_rx_pkg::EXP_SINGLE
		: (f_fixed ? fec_rx_pkg::EXP_FIXED : fec_rx_pkg::EXP_FLEX);

	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: if (take && s_sop && ctrl_en) next_state = ST_RTP1;
			ST_RTP1: if (take) next_state = ST_RTP2;
			ST_RTP2: if (take) next_state = ST_FEC0;
			ST_FEC0: begin
				if (take) begin
					if (s_data[fec_rx_pkg::FEC_R_BIT] && !s_data[fec_rx_pkg::FEC_F_BIT]) begin
						next_state = ST_SKIP;
					end else begin
						next_state = ST_FEC1;
					end
				end
			end
			ST_FEC1: if (take) next_state = ST_CSRC;
			ST_CSRC: if (take) next_state = is_retx ? ST_EXPAND : ST_BLK0;
			ST_BLK0: begin
				if (take) begin
					if (!f_fixed && s_data[fec_rx_pkg::BLK_K_BIT]) next_state = ST_MASK1;
					else next_state = ST_EXPAND;
				end
			end
			ST_MASK1: begin
				if (take) begin
					if (s_data[fec_rx_pkg::MASK1_K_BIT]) next_state = ST_MASK2;
					else next_state = ST_EXPAND;
				end
			end
			ST_MASK2: if (take) next_state = ST_MASK3;
			ST_MASK3: if (take) next_state = ST_EXPAND;
			ST_EXPAND: begin
				if (!exp_start && !exp_busy) begin
					if (eop_seen) next_state = ST_IDLE;
					else if (blocks_left > 4'h1) next_state = ST_CSRC;
					else next_state = ST_SKIP;
				end
			end
			ST_SKIP: if (take && s_eop) next_state = ST_IDLE;
		endcase
		// A packet that ends early drops back to idle
		if (take && s_eop && state != ST_IDLE && next_state != ST_EXPAND) begin
			next_state = ST_IDLE;
		end
	end

	always_comb begin
		set_bits = '0;
		if (take) begin
			unique case (state)
				ST_IDLE: begin
					if (s_sop && ctrl_en) begin
						set_bits[fec_rx_pkg::ST_MARKER] = s_data[fec_rx_pkg::RTP_M_BIT];
						set_bits[fec_rx_pkg::ST_SEQ] = have_sn
							&& (s_data[15:0] != fec_rx_pkg::sn_add(rtp_sn, 16'h0001));
					end
				end
				ST_RTP2: set_bits[fec_rx_pkg::ST_SSRC] = have_ssrc && (s_data != rep_ssrc);
				ST_FEC0: begin
					// Retransmission must carry a count of one; R without F is unusable
					set_bits[fec_rx_pkg::ST_FORMAT] = s_data[fec_rx_pkg::FEC_R_BIT]
						&& (!s_data[fec_rx_pkg::FEC_F_BIT]
						|| s_data[fec_rx_pkg::FEC_CC_LSB +: 4] != 4'h1);
				end
				ST_CSRC: set_bits[fec_rx_pkg::ST_SESSION] = (src_ssrc != 32'h0000_0000)
					&& (s_data != src_ssrc);
				ST_BLK0: begin
					if (f_fixed) begin
						unique case (cfg_top)
							fec_rx_pkg::TOP_NONINTERLEAVED: set_bits[fec_rx_pkg::ST_PATTERN] =
								(s_data[7:0] > 8'h01) || (s_data[15:8] != cfg_l - 8'h01);
							fec_rx_pkg::TOP_INTERLEAVED: set_bits[fec_rx_pkg::ST_PATTERN] =
								(s_data[7:0] <= 8'h01) || (s_data[15:8] != cfg_l)
								|| (s_data[7:0] != cfg_d - 8'h01);
							default: set_bits[fec_rx_pkg::ST_PATTERN] = 1'b0;
						endcase
					end
				end
				default: set_bits = '0;
			endcase
			if (s_eop && state != ST_IDLE && state != ST_SKIP && next_state != ST_EXPAND) begin
				set_bits[fec_rx_pkg::ST_FORMAT] = 1'b1;
			end
		end
		set_bits[fec_rx_pkg::ST_WINDOW] = us_tick && ctrl_en && have_sn
			&& (window_us != 32'h0000_0000) && (win_cnt + 32'h0000_0001 == window_us);
		if (wr && paddr == fec_rx_pkg::REG_RATE && pwdata <= fec_rx_pkg::MIN_RATE_HZ) begin
			set_bits[fec_rx_pkg::ST_CFG] = 1'b1;
		end
		if (wr && paddr == fec_rx_pkg::REG_LAYOUT
			&& pwdata[fec_rx_pkg::LAY_TOP_LSB +: 2] == fec_rx_pkg::TOP_RESERVED) begin
			set_bits[fec_rx_pkg::ST_CFG] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) state <= ST_IDLE;
		else state <= next_state;
	end

	// Header capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hdr0 <= 32'h0000_0000;
			ts_rec <= 32'h0000_0000;
			rtp_sn <= 16'h0000;
			rtp_ts <= 32'h0000_0000;
			rep_ssrc <= 32'h0000_0000;
			prot_ssrc <= 32'h0000_0000;
			have_sn <= 1'b0;
			have_ssrc <= 1'b0;
			blocks_left <= 4'h0;
			is_retx <= 1'b0;
			f_fixed <= 1'b0;
			base <= 16'h0000;
			mask <= '0;
			mask_len <= 8'h00;
			fm <= 8'h00;
			fn <= 8'h00;
			eop_seen <= 1'b0;
			hdr_valid <= 1'b0;
			pkt_count <= 32'h0000_0000;
		end else begin
			if (take) eop_seen <= s_eop;
			if (take) begin
				unique case (state)
					ST_IDLE: begin
						if (s_sop && ctrl_en) begin
							// First number is taken as is; its value is unpredictable
							rtp_sn <= s_data[15:0];
							have_sn <= 1'b1;
							hdr_valid <= 1'b0;
							pkt_count <= pkt_count + 32'h0000_0001;
							blocks_left <= (s_data[fec_rx_pkg::RTP_CC_LSB +: 4] == 4'h0)
								? 4'h1 : s_data[fec_rx_pkg::RTP_CC_LSB +: 4];
						end
					end
					ST_RTP1: rtp_ts <= s_data;
					ST_RTP2: begin
						rep_ssrc <= s_data;
						have_ssrc <= 1'b1;
					end
					ST_FEC0: begin
						hdr0 <= s_data;
						is_retx <= s_data[fec_rx_pkg::FEC_R_BIT] && s_data[fec_rx_pkg::FEC_F_BIT];
						f_fixed <= s_data[fec_rx_pkg::FEC_F_BIT];
						base <= s_data[15:0];
						hdr_valid <= 1'b1;
					end
					ST_FEC1: ts_rec <= s_data;
					ST_CSRC: prot_ssrc <= s_data;
					ST_BLK0: begin
						base <= s_data[31:16];
						mask[0:14] <= s_data[14:0];
						mask_len <= fec_rx_pkg::MASK_LEN0;
						fm <= s_data[15:8];
						fn <= s_data[7:0];
					end
					ST_MASK1: begin
						mask[15:45] <= s_data[30:0];
						mask_len <= fec_rx_pkg::MASK_LEN1;
					end
					ST_MASK2: mask[46:77] <= s_data;
					ST_MASK3: begin
						mask[78:109] <= s_data;
						mask_len <= fec_rx_pkg::MASK_LEN2;
					end
					default: begin
					end
				endcase
			end
			if (state == ST_EXPAND && next_state != ST_EXPAND) blocks_left <= blocks_left - 4'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) exp_start <= 1'b0;
		else exp_start <= (next_state == ST_EXPAND) && (state != ST_EXPAND);
	end

	fec_sn_expander u_expander (
		.pclk(pclk),
		.presetn(presetn),
		.start(exp_start),
		.mode(exp_mode),
		.base(base),
		.mask(mask),
		.mask_len(mask_len),
		.m_off(fm),
		.n_cnt(fn),
		.busy(exp_busy),
		.out_valid(prot_valid),
		.out_ready(prot_ready),
		.out_sn(prot_sn)
	);

	// Microsecond base for the repair window
	assign us_tick = (us_div == 7'(fec_rx_pkg::CYC_PER_US - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			us_div <= 7'h00;
			win_cnt <= 32'h0000_0000;
		end else begin
			us_div <= us_tick ? 7'h00 : us_div + 7'h01;
			if (take && state == ST_IDLE && s_sop) win_cnt <= 32'h0000_0000;
			else if (us_tick && win_cnt != window_us) win_cnt <= win_cnt + 32'h0000_0001;
		end
	end

	// APB slave, zero wait states
	assign pready = 1'b1;
	assign wr = psel && penable && pwrite;
	assign addr_ok = (paddr[1:0] == 2'h0) && (paddr <= fec_rx_pkg::REG_PKT_COUNT);
	assign pslverr = psel && penable && !addr_ok;

	always_comb begin
		unique case (paddr)
			fec_rx_pkg::REG_CTRL: rd_val = {31'h0000_0000, ctrl_en};
			fec_rx_pkg::REG_STATUS: rd_val = {22'h00_0000, state != ST_IDLE, hdr_valid, status};
			fec_rx_pkg::REG_RATE: rd_val = rate;
			fec_rx_pkg::REG_WINDOW: rd_val = window_us;
			fec_rx_pkg::REG_LAYOUT: rd_val = {14'h0000, cfg_top, cfg_d, cfg_l};
			fec_rx_pkg::REG_SRC_SSRC: rd_val = src_ssrc;
			fec_rx_pkg::REG_HDR0: rd_val = hdr0;
			fec_rx_pkg::REG_TSREC: rd_val = ts_rec;
			fec_rx_pkg::REG_RTP_SN: rd_val = {16'h0000, rtp_sn};
			fec_rx_pkg::REG_RTP_TS: rd_val = rtp_ts;
			fec_rx_pkg::REG_REP_SSRC: rd_val = rep_ssrc;
			fec_rx_pkg::REG_PKT_COUNT: rd_val = pkt_count;
			default: rd_val = 32'h0000_0000;
		endcase
	end

	// Read data is captured in the setup cycle so it leaves a flip-flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) prdata <= 32'h0000_0000;
		else if (psel && !penable) prdata <= (!pwrite && addr_ok) ? rd_val : 32'h0000_0000;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_en <= 1'b0;
			rate <= fec_rx_pkg::RATE_RST;
			window_us <= fec_rx_pkg::WINDOW_RST;
			cfg_l <= fec_rx_pkg::L_RST;
			cfg_d <= fec_rx_pkg::D_RST;
			cfg_top <= fec_rx_pkg::TOP_TWO_D;
			src_ssrc <= 32'h0000_0000;
		end else if (wr) begin
			unique case (paddr)
				fec_rx_pkg::REG_CTRL: ctrl_en <= pwdata[0];
				fec_rx_pkg::REG_RATE: rate <= pwdata;
				fec_rx_pkg::REG_WINDOW: window_us <= pwdata;
				fec_rx_pkg::REG_LAYOUT: begin
					cfg_l <= pwdata[fec_rx_pkg::LAY_L_LSB +: 8];
					cfg_d <= pwdata[fec_rx_pkg::LAY_D_LSB +: 8];
					cfg_top <= pwdata[fec_rx_pkg::LAY_TOP_LSB +: 2];
				end
				fec_rx_pkg::REG_SRC_SSRC: src_ssrc <= pwdata;
				default: begin
				end
			endcase
		end
	end

	// Set wins over a simultaneous write-one clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) status <= '0;
		else if (wr && paddr == fec_rx_pkg::REG_STATUS)
			status <= (status & ~pwdata[fec_rx_pkg::STICKY_W-1:0]) | set_bits;
		else status <= status | set_bits;
	end
endmodule

// file: verif/fec_repair_parser_asserts.sv
// Concurrent checks on the repair header parser ports
`timescale 1ns/1ns
module fec_repair_parser_asserts (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// Stream and protected numbers
	input wire logic s_ready,
	input wire logic prot_valid,
	input wire logic prot_ready,
	input wire logic [15:0] prot_sn,
	input wire logic [31:0] prot_ssrc
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic bad_addr;
	assign bad_addr = paddr > fec_rx_pkg::REG_PKT_COUNT || paddr[1:0] != 2'h0;
	a_ready_high: assert property (pready)
		else $error("pready low");
	a_err_range: assert property (psel && penable && bad_addr |-> pslverr && prdata == 32'h0)
		else $error("bad address not refused");
	a_err_clear: assert property (psel && penable && !bad_addr |-> !pslverr)
		else $error("good address refused");
	a_prot_hold: assert property (prot_valid && !prot_ready |=> prot_valid && $stable(prot_sn) && $stable(prot_ssrc))
		else $error("protected number dropped while stalled");
	a_prot_step: assert property (prot_valid && prot_ready |=> !prot_valid)
		else $error("no gap after accepted number");
	a_stall_busy: assert property (prot_valid |-> !s_ready)
		else $error("stream taken during expansion");
	a_expand_len: assert property ($fell(s_ready) |-> ##[1:600] s_ready)
		else $error("expansion too long");
	a_first_hit: assert property ($fell(s_ready) |-> !prot_valid ##1 !prot_valid)
		else $error("number before expansion start");
	a_reset_idle: assert property ($rose(presetn) |-> !prot_valid && s_ready && prdata == 32'h0)
		else $error("outputs not idle after reset");
endmodule
bind fec_repair_parser fec_repair_parser_asserts u_chk (.pclk(pclk), .presetn(presetn),
	.paddr(paddr), .psel(psel), .penable(penable), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .s_ready(s_ready), .prot_valid(prot_valid), .prot_ready(prot_ready),
	.prot_sn(prot_sn), .prot_ssrc(prot_ssrc));

// file: verif/fec_repair_source.sv
// Behavioural repair packet source feeding the parser stream
`timescale 1ns/1ns
module fec_repair_source #(
	parameter logic [31:0] REP_SSRC = 32'h6e21_a5f0,
	parameter logic [15:0] SN_INIT = 16'h3b6d
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Packet order
	input wire logic go,
	input wire logic bad,
	input wire logic rtx,
	input wire logic fixed,
	input wire logic [15:0] base,
	input wire logic [31:0] blk,
	input wire logic [31:0] csrc,
	output logic busy,
	// Word stream
	output logic s_valid,
	output logic s_sop,
	output logic s_eop,
	output logic [31:0] s_data,
	input wire logic s_ready
);
	logic [31:0] w [0:7];
	logic [31:0] ts;
	logic [15:0] sn;
	logic [2:0] idx;
	logic [2:0] last;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ts <= 32'h0;
		end else begin
			ts <= ts + 32'h1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy <= 1'h0;
			s_valid <= 1'h0;
			s_sop <= 1'h0;
			s_eop <= 1'h0;
			s_data <= 32'h0;
			idx <= 3'h0;
			last <= 3'h7;
			sn <= SN_INIT;
		end else if (go && !busy) begin
			w[0] <= {8'h81, bad, 7'h60, sn};
			w[1] <= ts;
			w[2] <= REP_SSRC;
			w[3] <= {rtx, fixed, 6'h01, 1'h0, 7'h60, rtx ? base : 16'h0004};
			w[4] <= ts;
			w[5] <= csrc;
			w[6] <= rtx ? 32'h0bad_cafe : blk;
			w[7] <= 32'h1234_5678;
			last <= rtx ? 3'h6 : 3'h7;
			// A bad order also skips a number so the next packet shows a gap
			sn <= sn + (bad ? 16'h0002 : 16'h0001);
			idx <= 3'h0;
			busy <= 1'h1;
		end else if (busy && (!s_valid || s_ready)) begin
			if (s_valid && s_eop) begin
				busy <= 1'h0;
				s_valid <= 1'h0;
				s_eop <= 1'h0;
				s_data <= ~s_data;
			end else begin
				s_valid <= 1'h1;
				s_data <= w[idx];
				s_sop <= idx == 3'h0;
				s_eop <= idx == last;
				idx <= idx + 3'h1;
			end
		end else if (!busy) begin
			s_data <= ~s_data; // Idle bus never shows a stale word
		end
	end
endmodule

// file: verif/fec_repair_parser_tb_top.sv
// Self-checking bench for the repair header parser
`timescale 1ns/1ns
module fec_repair_parser_tb_top;
	localparam logic [31:0] CSRC = 32'h1b2c_3d4e;
	localparam logic [31:0] REP_SSRC = 32'h6e21_a5f0; // Arbitrary value
	localparam logic [15:0] SN_INIT = 16'h3b6d; // Arbitrary value
	typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] m; logic [31:0] e; logic er;} row_t;
	row_t rows [18] = '{
		'{1'h0, 12'h000, 32'h0, 32'hffff_ffff, 32'h0, 1'h0},
		'{1'h0, 12'h008, 32'h0, 32'hffff_ffff, fec_rx_pkg::RATE_RST, 1'h0},
		'{1'h0, 12'h00c, 32'h0, 32'hffff_ffff, 32'h0, 1'h0},
		'{1'h0, 12'h010, 32'h0, 32'hffff_ffff, 32'h0002_0101, 1'h0},
		'{1'h0, 12'h030, 32'h0, 32'hffff_ffff, 32'h0, 1'h1},
		'{1'h0, 12'h002, 32'h0, 32'hffff_ffff, 32'h0, 1'h1},
		'{1'h1, 12'h010, 32'h0001_0103, 32'h0, 32'h0, 1'h0},
		'{1'h0, 12'h010, 32'h0, 32'hffff_ffff, 32'h0001_0103, 1'h0},
		'{1'h1, 12'h008, 32'h0000_03e8, 32'h0, 32'h0, 1'h0},
		'{1'h0, 12'h004, 32'h0, 32'h0000_0080, 32'h0000_0080, 1'h0},
		'{1'h1, 12'h004, 32'h0000_00ff, 32'h0, 32'h0, 1'h0},
		'{1'h0, 12'h004, 32'h0, 32'h0000_00ff, 32'h0, 1'h0},
		'{1'h1, 12'h014, CSRC, 32'h0, 32'h0, 1'h0},
		'{1'h1, 12'h00c, 32'h0000_0005, 32'h0, 32'h0, 1'h0},
		'{1'h1, 12'h000, 32'h0000_0001, 32'h0, 32'h0, 1'h0},
		'{1'h0, 12'h00c, 32'h0, 32'hffff_ffff, 32'h0, 1'h0},
		'{1'h0, 12'h010, 32'h0, 32'hffff_ffff, 32'h0002_0101, 1'h0},
		'{1'h0, 12'h000, 32'h0, 32'hffff_ffff, 32'h0, 1'h0}};
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, blk = 32'h0;
	logic go = 1'h0, bad = 1'h0, rtx = 1'h0, fixed = 1'h0, prot_ready = 1'h0;
	logic [15:0] base = 16'h0, sn_exp;
	logic [1:0] cnt = 2'h0;
	logic pready, pslverr, s_valid, s_sop, s_eop, s_ready, prot_valid, busy;
	logic [31:0] prdata, s_data, prot_ssrc;
	logic [15:0] prot_sn;
	logic [15:0] exp_q [$];
	int n_errors = 0;
	int cmp_count = 0;
	always #5 pclk = ~pclk;
	fec_repair_parser u_fec_repair_parser (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .s_valid(s_valid), .s_sop(s_sop), .s_eop(s_eop),
		.s_data(s_data), .s_ready(s_ready), .prot_valid(prot_valid), .prot_ready(prot_ready),
		.prot_sn(prot_sn), .prot_ssrc(prot_ssrc));
	fec_repair_source #(.REP_SSRC(REP_SSRC), .SN_INIT(SN_INIT)) u_fec_repair_source (
		.pclk(pclk), .presetn(presetn), .go(go), .bad(bad), .rtx(rtx), .fixed(fixed),
		.base(base), .blk(blk), .csrc(CSRC), .busy(busy), .s_valid(s_valid), .s_sop(s_sop),
		.s_eop(s_eop), .s_data(s_data), .s_ready(s_ready));
	task automatic test_done();
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		cmp_count++;
		if (got !== ex) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] rd;
		logic er;
		apb(1'h0, a, 32'h0, rd, er);
		chk(nm, e, rd & m);
	endtask
	task automatic run_rows(input int lo, input int hi);
		logic [31:0] rd;
		logic er;
		for (int i = lo; i <= hi; i++) begin
			apb(rows[i].w, rows[i].a, rows[i].d, rd, er);
			chk($sformatf("pslverr row %0d", i), {31'h0, rows[i].er}, {31'h0, er});
			if (!rows[i].w) chk($sformatf("prdata row %0d", i), rows[i].e, rd & rows[i].m);
		end
	endtask
	// Packet order to the source, then wait until every expected number came out
	task automatic send(input logic rt, input logic fx, input logic bd, input logic [15:0] b,
		input logic [31:0] k);
		int i;
		@(posedge pclk);
		rtx <= rt;
		fixed <= fx;
		bad <= bd;
		base <= b;
		blk <= k;
		go <= 1'h1;
		do @(posedge pclk); while (busy !== 1'h1);
		go <= 1'h0;
		do @(posedge pclk); while (busy !== 1'h0);
		for (i = 0; i < 400 && exp_q.size() != 0; i++) @(posedge pclk);
		chk("numbers left", 32'h0, 32'(exp_q.size()));
	endtask
	// Consumer stalls one cycle in four so held outputs get exercised
	always @(posedge pclk) begin
		cnt <= cnt + 2'h1;
		prot_ready <= cnt != 2'h0;
		if (prot_valid === 1'h1 && prot_ready === 1'h1) begin
			sn_exp = 16'hxxxx;
			if (exp_q.size() != 0) sn_exp = exp_q.pop_front();
			chk("prot_sn", {16'h0, sn_exp}, {16'h0, prot_sn});
			chk("prot_ssrc", CSRC, prot_ssrc);
		end
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_errors++;
		test_done();
	end
	initial begin
		logic [31:0] rd;
		logic er;
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		run_rows(0, 14);
		exp_q = {16'hfffe, 16'hffff, 16'h0000};
		send(1'h0, 1'h1, 1'h0, 16'hfffe, {16'hfffe, 8'h02, 8'h00});
		rd_chk("status clean", fec_rx_pkg::REG_STATUS, 32'h39, 32'h0);
		exp_q = {16'h0101, 16'h0104};
		send(1'h0, 1'h0, 1'h0, 16'h0100, {16'h0100, 1'h0, 15'h4800});
		rd_chk("status seq", fec_rx_pkg::REG_STATUS, 32'h3b, 32'h0);
		exp_q = {16'h0010, 16'h0013, 16'h0016};
		send(1'h0, 1'h1, 1'h0, 16'h0010, {16'h0010, 8'h03, 8'h02});
		rd_chk("status pattern", fec_rx_pkg::REG_STATUS, 32'h10, 32'h10);
		exp_q = {16'h0020, 16'h0021, 16'h0022};
		send(1'h0, 1'h1, 1'h1, 16'h0020, {16'h0020, 8'h02, 8'h00});
		rd_chk("status marker", fec_rx_pkg::REG_STATUS, 32'h01, 32'h01);
		exp_q = {16'h0040};
		send(1'h1, 1'h1, 1'h0, 16'h0040, 32'h0);
		rd_chk("status gap", fec_rx_pkg::REG_STATUS, 32'h02, 32'h02);
		rd_chk("hdr0", fec_rx_pkg::REG_HDR0, 32'hffff_ffff, 32'hc160_0040);
		rd_chk("rtp sn", fec_rx_pkg::REG_RTP_SN, 32'h0000_ffff, {16'h0, SN_INIT + 16'h0005});
		rd_chk("rep ssrc", fec_rx_pkg::REG_REP_SSRC, 32'hffff_ffff, REP_SSRC);
		apb(1'h1, fec_rx_pkg::REG_STATUS, 32'h0000_00ff, rd, er);
		repeat (300) @(posedge pclk);
		rd_chk("window early", fec_rx_pkg::REG_STATUS, 32'h40, 32'h0);
		repeat (300) @(posedge pclk);
		rd_chk("window late", fec_rx_pkg::REG_STATUS, 32'h40, 32'h40);
		@(posedge pclk);
		presetn <= 1'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'h1;
		run_rows(15, 17);
		test_done();
	end
endmodule
